// >>> core/hpd_map.svh
// Purpose: offsets, field positions, reset values and codes of the host port
// Assumes: included by bare name from the package file, the checker and the bench
// Notes:   definitions only
`ifndef HPD_MAP_SVH
`define HPD_MAP_SVH

// ----------------------------------------------------------------------
// host-side byte addresses
// ----------------------------------------------------------------------
`define HPD_HA_ICR 3'h0
`define HPD_HA_CVR 3'h1
`define HPD_HA_ISR 3'h2
`define HPD_HA_DHI 3'h5
`define HPD_HA_DMID 3'h6
`define HPD_HA_DLO 3'h7

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define HPD_ST_RXFULL 0
`define HPD_ST_TXEMPTY 1
`define HPD_FLAG_LO 3
`define HPD_FLAG_HI 4
`define HPD_ICR_RX_REQUEST_ENABLE 0
`define HPD_ICR_TX_REQUEST_ENABLE 1
`define HPD_CVR_REQ 7

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define HPD_WORD_W 24
`define HPD_FIFO_D 4
`define HPD_ICR_RST 5'h00
`define HPD_WORD_RST 24'h000000
`define HPD_VEC_RST 7'h00

// ----------------------------------------------------------------------
// dma request source codes
// ----------------------------------------------------------------------
`define HPD_DRS_RXFULL 5'h13
`define HPD_DRS_TXEMPTY 5'h14

`endif

// >>> core/hpd_pkg.sv
// Purpose: types shared by the host port design
// Assumes: hpd_map.svh is on the include path
// Notes:   constants live in the header, types live here
`include "hpd_map.svh"

package hpd_pkg;

  // ----------------------------------------------------------------------
  // host register select
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    HPD_SEL_ICR  = 3'b000,
    HPD_SEL_CVR  = 3'b001,
    HPD_SEL_ISR  = 3'b010,
    HPD_SEL_NONE = 3'b011,
    HPD_SEL_RSV  = 3'b100,
    HPD_SEL_DHI  = 3'b101,
    HPD_SEL_DMID = 3'b110,
    HPD_SEL_DLO  = 3'b111
  } hpd_hsel_t;

endpackage

// >>> core/hpd_sync.sv
// Purpose: two flip-flop synchroniser for a group of pin levels
// Assumes: inputs come from outside the core_clk domain
// Notes:   first stage feeds only the second stage
module hpd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = rst_n ? pin_in : RST;
    sync_d = rst_n ? meta_q : RST;
  end

  always_ff @(posedge core_clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign pin_out = sync_q;

endmodule

// >>> core/hpd_fifo.sv
// Purpose: small word buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   depth must be a power of two
module hpd_fifo #(
  parameter int W = 24,
  parameter int D = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [W-1:0] mem_d [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] wr_d;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  // room is left while fewer than D words are held
  assign in_ready = (cnt_q < (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    if (!rst_n) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    mem_q <= mem_d;
    wr_q <= wr_d;
    rd_q <= rd_d;
    cnt_q <= cnt_d;
  end

endmodule

// >>> core/hpd_top.sv
// Purpose: double-buffered byte-wide host port datapath and handshake
// Assumes: host pins are asynchronous to core_clk; core side is on core_clk
// Notes:   core control and status bits are plain ports
//
// How it works
// - one host address for both data directions
// - port only answers, never masters the bus
// - host bytes move to 4-word buffer when it has room
// - core word moves to host when host read
// - core status: tx empty bit1, rx full bit0
// - host status: tx empty bit1, rx full bit0
// - core flags mirrored to host status 4:3
// - host flags mirrored to core status 4:3
// - enabled status condition raises core interrupt request
// - separate enables for rx, tx, command
// - rx clears on core read, tx on write
// - command vector address is twice the vector
// - interrupt acknowledge clears pending command
// - command interrupt independent of data paths
// - stop mode ignores host strobes and stops data drive; host request pins and buffers keep running
// - dma sources: rx full 10011, tx empty 10100
module hpd_top import hpd_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  // host pins
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  output logic host_tx_req_n,
  output logic host_rx_req_n,
  // core control bits
  input wire logic rx_full_irq_enable,
  input wire logic tx_empty_irq_enable,
  input wire logic command_irq_enable,
  input wire logic [1:0] core_to_host_flags,
  input wire logic core_stop,
  // core data access
  input wire logic core_rx_rd,
  output logic [23:0] core_rx_word_reg,
  input wire logic core_tx_wr,
  input wire logic [23:0] core_tx_data,
  // core status and requests
  output logic [4:0] core_stat_reg,
  output logic rx_irq_req,
  output logic tx_irq_req,
  output logic cmd_irq_req,
  output logic [7:0] cmd_vector_addr,
  input wire logic cmd_ack,
  input wire logic [4:0] dma_request_source_field,
  output logic dma_req
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [13:0] pin_raw;
  logic [13:0] pin_sync;
  logic s_cs_n;
  logic s_rd_n;
  logic s_wr_n;
  logic [2:0] s_addr;
  logic [7:0] s_data;

  assign pin_raw = {host_cs_n, host_rd_n, host_wr_n, host_addr, host_data_in};

  hpd_sync #(
    .W(14),
    .RST(14'h3800)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(pin_raw),
    .pin_out(pin_sync)
  );

  assign s_cs_n = pin_sync[13];
  assign s_rd_n = pin_sync[12];
  assign s_wr_n = pin_sync[11];
  assign s_addr = pin_sync[10:8];
  assign s_data = pin_sync[7:0];

  // ----------------------------------------------------------------------
  // host strobe decode
  // ----------------------------------------------------------------------
  logic rd_act;
  logic wr_act;
  logic rd_act_q;
  logic wr_act_q;
  logic [2:0] wadr_q;
  logic [7:0] wdat_q;
  logic [2:0] radr_q;
  logic wr_done;
  logic rd_done;
  hpd_hsel_t wsel;
  hpd_hsel_t rsel;
  hpd_hsel_t cur_sel;

  // in stop mode the pins are treated as idle
  assign rd_act = !core_stop && !s_cs_n && !s_rd_n;
  assign wr_act = !core_stop && !s_cs_n && !s_wr_n;
  // act at the end of each strobe, with values held from its last cycle
  assign wr_done = wr_act_q && !wr_act && !core_stop;
  assign rd_done = rd_act_q && !rd_act && !core_stop;
  assign wsel = hpd_hsel_t'(wadr_q);
  assign rsel = hpd_hsel_t'(radr_q);
  assign cur_sel = hpd_hsel_t'(s_addr);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [4:0] icr_q, icr_d;
  logic [6:0] vec_q, vec_d;
  logic cmd_pend_q, cmd_pend_d;
  logic [23:0] htx_q, htx_d;
  logic htx_full_q, htx_full_d;
  logic [23:0] hrx_q, hrx_d;
  logic hrx_full_q, hrx_full_d;
  logic [23:0] crx_q, crx_d;
  logic crx_full_q, crx_full_d;
  logic [23:0] ctx_q, ctx_d;
  logic ctx_empty_q, ctx_empty_d;
  logic [7:0] dout_q, dout_d;
  logic oe_q, oe_d;
  logic rd_act_d;
  logic wr_act_d;
  logic [2:0] wadr_d;
  logic [7:0] wdat_d;
  logic [2:0] radr_d;

  // ----------------------------------------------------------------------
  // host to core buffer
  // ----------------------------------------------------------------------
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [23:0] fifo_out_data;
  logic push;
  logic load_crx;

  // host bytes stay full until the buffer accepts them
  assign push = htx_full_q && fifo_in_ready;
  assign fifo_out_ready = !crx_full_q;
  assign load_crx = fifo_out_valid && fifo_out_ready;

  hpd_fifo #(
    .W(`HPD_WORD_W),
    .D(`HPD_FIFO_D)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(htx_full_q),
    .in_ready(fifo_in_ready),
    .in_data(htx_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------------
  // status views
  // ----------------------------------------------------------------------
  logic [7:0] isr_val;
  logic xfer_c2h;

  always_comb begin
    isr_val = 8'h00;
    isr_val[`HPD_ST_RXFULL] = hrx_full_q;
    isr_val[`HPD_ST_TXEMPTY] = !htx_full_q;
    isr_val[`HPD_FLAG_HI:`HPD_FLAG_LO] = core_to_host_flags;
    core_stat_reg = 5'h00;
    core_stat_reg[`HPD_ST_RXFULL] = crx_full_q;
    core_stat_reg[`HPD_ST_TXEMPTY] = ctx_empty_q;
    core_stat_reg[`HPD_FLAG_HI:`HPD_FLAG_LO] = icr_q[`HPD_FLAG_HI:`HPD_FLAG_LO];
  end

  // core word goes out only once the host has read the previous one
  assign xfer_c2h = !ctx_empty_q && !hrx_full_q;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    icr_d = icr_q;
    vec_d = vec_q;
    cmd_pend_d = cmd_pend_q;
    htx_d = htx_q;
    htx_full_d = htx_full_q;
    hrx_d = hrx_q;
    hrx_full_d = hrx_full_q;
    crx_d = crx_q;
    crx_full_d = crx_full_q;
    ctx_d = ctx_q;
    ctx_empty_d = ctx_empty_q;
    rd_act_d = rd_act;
    wr_act_d = wr_act;
    wadr_d = wr_act ? s_addr : wadr_q;
    wdat_d = wr_act ? s_data : wdat_q;
    radr_d = rd_act ? s_addr : radr_q;
    oe_d = rd_act;
    dout_d = dout_q;

    // read data follows the address while the strobe stands
    if (rd_act) begin
      case (cur_sel)
        HPD_SEL_ICR: dout_d = {3'h0, icr_q};
        HPD_SEL_CVR: dout_d = {cmd_pend_q, vec_q};
        HPD_SEL_ISR: dout_d = isr_val;
        HPD_SEL_DHI: dout_d = hrx_q[23:16];
        HPD_SEL_DMID: dout_d = hrx_q[15:8];
        HPD_SEL_DLO: dout_d = hrx_q[7:0];
        default: dout_d = 8'h00;
      endcase
    end

    // buffer hand-offs
    if (push) begin
      htx_full_d = 1'b0;
    end
    if (load_crx) begin
      crx_d = fifo_out_data;
      crx_full_d = 1'b1;
    end
    if (xfer_c2h) begin
      hrx_d = ctx_q;
      hrx_full_d = 1'b1;
      ctx_empty_d = 1'b1;
    end

    // host read of the low byte frees the host receive bytes
    // a read of empty bytes must not cancel a word that arrives in the same cycle
    if (rd_done && rsel == HPD_SEL_DLO && hrx_full_q) begin
      hrx_full_d = 1'b0;
    end

    // host writes; the same address loads the transmit bytes
    if (wr_done) begin
      case (wsel)
        HPD_SEL_ICR: icr_d = wdat_q[4:0];
        HPD_SEL_CVR: begin
          vec_d = wdat_q[6:0];
          if (wdat_q[`HPD_CVR_REQ]) begin
            cmd_pend_d = 1'b1;
          end
        end
        HPD_SEL_DHI: htx_d[23:16] = wdat_q;
        HPD_SEL_DMID: htx_d[15:8] = wdat_q;
        HPD_SEL_DLO: begin
          htx_d[7:0] = wdat_q;
          htx_full_d = 1'b1;
        end
        default: icr_d = icr_q;
      endcase
    end

    // core side accesses
    if (core_rx_rd && crx_full_q) begin
      crx_full_d = 1'b0;
    end
    if (core_tx_wr) begin
      ctx_d = core_tx_data;
      ctx_empty_d = 1'b0;
    end

    // acknowledge clears, but a fresh host request in the same cycle wins
    if (cmd_ack && !(wr_done && wsel == HPD_SEL_CVR && wdat_q[`HPD_CVR_REQ])) begin
      cmd_pend_d = 1'b0;
    end

    if (!rst_n) begin
      icr_d = `HPD_ICR_RST;
      vec_d = `HPD_VEC_RST;
      cmd_pend_d = 1'b0;
      htx_d = `HPD_WORD_RST;
      htx_full_d = 1'b0;
      hrx_d = `HPD_WORD_RST;
      hrx_full_d = 1'b0;
      crx_d = `HPD_WORD_RST;
      crx_full_d = 1'b0;
      ctx_d = `HPD_WORD_RST;
      ctx_empty_d = 1'b1;
      rd_act_d = 1'b0;
      wr_act_d = 1'b0;
      wadr_d = 3'h0;
      wdat_d = 8'h00;
      radr_d = 3'h0;
      oe_d = 1'b0;
      dout_d = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    icr_q <= icr_d;
    vec_q <= vec_d;
    cmd_pend_q <= cmd_pend_d;
    htx_q <= htx_d;
    htx_full_q <= htx_full_d;
    hrx_q <= hrx_d;
    hrx_full_q <= hrx_full_d;
    crx_q <= crx_d;
    crx_full_q <= crx_full_d;
    ctx_q <= ctx_d;
    ctx_empty_q <= ctx_empty_d;
    rd_act_q <= rd_act_d;
    wr_act_q <= wr_act_d;
    wadr_q <= wadr_d;
    wdat_q <= wdat_d;
    radr_q <= radr_d;
    oe_q <= oe_d;
    dout_q <= dout_d;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign host_data_out = dout_q;
  assign host_data_oe_n = !(oe_q && !core_stop);
  assign host_tx_req_n = !(icr_q[`HPD_ICR_TX_REQUEST_ENABLE] && !htx_full_q);
  assign host_rx_req_n = !(icr_q[`HPD_ICR_RX_REQUEST_ENABLE] && hrx_full_q);

  assign core_rx_word_reg = crx_q;
  assign rx_irq_req = rx_full_irq_enable && crx_full_q;
  assign tx_irq_req = tx_empty_irq_enable && ctx_empty_q;
  assign cmd_irq_req = command_irq_enable && cmd_pend_q;
  assign cmd_vector_addr = {vec_q, 1'b0};

  // core-side dma only; host registers are never touched by it
  assign dma_req = (dma_request_source_field == `HPD_DRS_RXFULL && crx_full_q)
                || (dma_request_source_field == `HPD_DRS_TXEMPTY && ctx_empty_q);

endmodule

// >>> bench/hpd_top_checker.sv
// Purpose: concurrent checks on the host port top ports
// Assumes: hpd_map.svh on the include path
// Notes:   bound to hpd_top after the module
`include "hpd_map.svh"
module hpd_top_checker import hpd_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_data_oe_n,
  input wire logic rx_full_irq_enable,
  input wire logic tx_empty_irq_enable,
  input wire logic command_irq_enable,
  input wire logic core_stop,
  input wire logic core_rx_rd,
  input wire logic [23:0] core_rx_word_reg,
  input wire logic core_tx_wr,
  input wire logic [4:0] core_stat_reg,
  input wire logic rx_irq_req,
  input wire logic tx_irq_req,
  input wire logic cmd_irq_req,
  input wire logic [7:0] cmd_vector_addr,
  input wire logic cmd_ack,
  input wire logic [4:0] dma_request_source_field,
  input wire logic dma_req
);
  timeunit 1ns;
  timeprecision 100ps;
  // cycles since the host read strobe was last seen on the pins
  logic [3:0] idle_q, idle_d;
  always_comb begin
    idle_d = idle_q;
    if (!host_cs_n && !host_rd_n) idle_d = 4'h0;
    else if (idle_q != 4'hf) idle_d = idle_q + 4'h1;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) idle_q <= 4'hf;
    else idle_q <= idle_d;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_rx_irq_map: assert property (rx_irq_req == (rx_full_irq_enable && core_stat_reg[0]))
    else $error("rx irq mismatch");
  chk_tx_irq_map: assert property (tx_irq_req == (tx_empty_irq_enable && core_stat_reg[1]))
    else $error("tx irq mismatch");
  chk_cmd_mask: assert property (cmd_irq_req |-> command_irq_enable)
    else $error("cmd irq unmasked");
  chk_cmd_ack_clr: assert property (cmd_ack && host_wr_n && $past(host_wr_n, 4) |=> !cmd_irq_req)
    else $error("cmd ack no clear");
  chk_vec_even: assert property (cmd_irq_req |-> !cmd_vector_addr[0])
    else $error("odd vector address");
  chk_cmd_hold: assert property (cmd_irq_req && !cmd_ack |=>
    cmd_irq_req || !command_irq_enable)
    else $error("cmd request dropped");
  chk_rx_hold: assert property (core_stat_reg[0] && !core_rx_rd |=>
    core_stat_reg[0] && $stable(core_rx_word_reg))
    else $error("rx word lost");
  chk_tx_clr: assert property ($fell(core_stat_reg[1]) |-> $past(core_tx_wr))
    else $error("tx empty cleared");
  chk_rsv_zero: assert property (core_stat_reg[2] == 1'b0)
    else $error("status bit2 set");
  chk_dma_rx: assert property ((dma_request_source_field == `HPD_DRS_RXFULL
    && core_stat_reg[0]) [*2] |-> dma_req)
    else $error("dma rx missing");
  chk_dma_off: assert property ((dma_request_source_field != `HPD_DRS_RXFULL
    && dma_request_source_field != `HPD_DRS_TXEMPTY) [*2] |-> !dma_req)
    else $error("dma spurious");
  chk_stop_oe: assert property (core_stop [*2] |-> host_data_oe_n)
    else $error("drive in stop");
  chk_slave_oe: assert property (!host_data_oe_n |-> idle_q < 4'h7)
    else $error("drive without read");
  cov_rx: cover property ($rose(core_stat_reg[0]));
  cov_cmd: cover property ($rose(cmd_irq_req));
  cov_dma: cover property (dma_req);
  cov_oe: cover property (!host_data_oe_n);
endmodule

bind hpd_top hpd_top_checker u_chk (.core_clk, .rst_n, .host_cs_n, .host_rd_n, .host_wr_n,
  .host_data_oe_n, .rx_full_irq_enable, .tx_empty_irq_enable, .command_irq_enable,
  .core_stop, .core_rx_rd, .core_rx_word_reg, .core_tx_wr, .core_stat_reg, .rx_irq_req,
  .tx_irq_req, .cmd_irq_req, .cmd_vector_addr, .cmd_ack, .dma_request_source_field, .dma_req);

// >>> bench/hpd_host_model.sv
// Purpose: external host master on the byte bus
// Assumes: strobe 6 cycles; write data 3 past strobe then 4 idle, 7 idle after a read
// Notes:   tasks are called from the bench top
module hpd_host_model (
  input wire logic core_clk,
  output logic host_cs_n,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic [2:0] host_addr,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic oe_seen;
  initial begin
    {host_cs_n, host_rd_n, host_wr_n} = 3'b111;
    host_addr = 3'h3;
    host_data_in = 8'h00;
    oe_seen = 1'b1;
  end
  // only the host starts a transfer
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk); #1;
    host_addr = a;
    host_data_in = d;
    {host_cs_n, host_wr_n} = 2'b00;
    repeat (6) @(posedge core_clk); #1;
    {host_cs_n, host_wr_n} = 2'b11;
    repeat (3) @(posedge core_clk); #1;
    host_data_in = ~d;  // released lines show no stale value
    repeat (4) @(posedge core_clk); #1;
  endtask
  // status is polled over the bus
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk); #1;
    host_addr = a;
    {host_cs_n, host_rd_n} = 2'b00;
    repeat (6) @(posedge core_clk); #1;
    d = host_data_out;
    oe_seen = host_data_oe_n;
    {host_cs_n, host_rd_n} = 2'b11;
    repeat (7) @(posedge core_clk); #1;
  endtask
endmodule

// >>> bench/hpd_top_tb.sv
// Purpose: self-checking bench for the host port
// Assumes: host pins driven by hpd_host_model
// Notes:   random data from a fixed-seed lfsr
`include "hpd_map.svh"
module hpd_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst_n, host_cs_n, host_rd_n, host_wr_n, host_data_oe_n, host_tx_req_n;
  logic host_rx_req_n, rx_full_irq_enable, tx_empty_irq_enable, command_irq_enable;
  logic core_stop, core_rx_rd, core_tx_wr, rx_irq_req, tx_irq_req, cmd_irq_req, cmd_ack, dma_req;
  logic [2:0] host_addr;
  logic [7:0] host_data_in, host_data_out, cmd_vector_addr, r8;
  logic [1:0] core_to_host_flags;
  logic [23:0] core_rx_word_reg, core_tx_data, w;
  logic [4:0] core_stat_reg, dma_request_source_field;
  logic [6:0] v;
  logic [31:0] seed = 32'he7dc26c5;
  logic [23:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  wire logic [5:0] mon = {cmd_irq_req, core_stat_reg};
  hpd_top uut (.core_clk, .rst_n, .host_cs_n, .host_rd_n, .host_wr_n, .host_addr,
    .host_data_in, .host_data_out, .host_data_oe_n, .host_tx_req_n, .host_rx_req_n,
    .rx_full_irq_enable, .tx_empty_irq_enable, .command_irq_enable, .core_to_host_flags,
    .core_stop, .core_rx_rd, .core_rx_word_reg, .core_tx_wr, .core_tx_data, .core_stat_reg,
    .rx_irq_req, .tx_irq_req, .cmd_irq_req, .cmd_vector_addr, .cmd_ack,
    .dma_request_source_field, .dma_req);
  hpd_host_model host (.core_clk, .host_cs_n, .host_rd_n, .host_wr_n, .host_addr,
    .host_data_in, .host_data_out, .host_data_oe_n);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_dma(input logic [4:0] c, input logic [1:0] st);
    return (c == `HPD_DRS_RXFULL && st[0]) || (c == `HPD_DRS_TXEMPTY && st[1]);
  endfunction
  function automatic logic [7:0] vaddr(input logic [6:0] x);
    return 8'(x) * 8'h02;
  endfunction
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic waitb(input int k, input logic b);
    for (int i = 0; i < 100 && mon[k] !== b; i++) tick(1);
    chk(mon[k] === b, "wait timeout");
  endtask
  // one-cycle core strobe: 0 read rx, 1 write tx, 2 command ack
  task automatic pulse(input int k);
    {core_rx_rd, core_tx_wr, cmd_ack} = 3'b100 >> k;
    tick(1);
    {core_rx_rd, core_tx_wr, cmd_ack} = 3'b000;
    tick(1);
  endtask
  task automatic hw(input logic [23:0] d);
    host.wr(`HPD_HA_DHI, d[23:16]);
    host.wr(`HPD_HA_DMID, d[15:8]);
    host.wr(`HPD_HA_DLO, d[7:0]);
  endtask
  task automatic hr(output logic [23:0] d);
    host.rd(`HPD_HA_DHI, d[23:16]);
    host.rd(`HPD_HA_DMID, d[15:8]);
    host.rd(`HPD_HA_DLO, d[7:0]);
  endtask
  task automatic dma_chk(input logic full);
    logic [4:0] c [3];
    c = '{`HPD_DRS_RXFULL, `HPD_DRS_TXEMPTY, 5'h1f};
    foreach (c[j]) begin
      dma_request_source_field = c[j];
      tick(3);
      chk(dma_req === exp_dma(c[j], {1'b1, full}), "dma request");
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {rst_n, rx_full_irq_enable, tx_empty_irq_enable, command_irq_enable, core_stop} = '0;
    {core_rx_rd, core_tx_wr, cmd_ack, core_to_host_flags, core_tx_data} = '0;
    dma_request_source_field = 5'h00;
    tick(10);
    rst_n = 1'b1;
    tick(1);
    chk(core_stat_reg === 5'h02 && host_data_oe_n === 1'b1, "reset status");
    chk({host_tx_req_n, host_rx_req_n} === 2'b11, "reset requests");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      core_to_host_flags = seed[1:0];
      host.wr(`HPD_HA_ICR, {3'h0, seed[3:2], 1'b0, seed[5:4]});
      chk(core_stat_reg[4:3] === seed[3:2], "host flags");
      chk(host_tx_req_n === ~seed[5] && host_rx_req_n === 1'b1, "requests");
      host.rd(`HPD_HA_ISR, r8);
      chk(r8[4:3] === seed[1:0] && host.oe_seen === 1'b0, "core flags");
    end
    $display("test flags done");
    host.wr(`HPD_HA_ICR, 8'h01);
    exp_q = {};
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      core_tx_data = seed[23:0];
      exp_q.push_back(seed[23:0]);
      pulse(1);
      tick(3);
      if (i == 0) waitb(1, 1'b1);
    end
    tick(10);
    chk(core_stat_reg[1] === 1'b0 && host_rx_req_n === 1'b0, "tx word held");
    host.rd(`HPD_HA_ISR, r8);
    chk(r8[0] === 1'b1, "rx bytes full");
    for (int i = 0; i < 2; i++) begin
      hr(w);
      chk(w === exp_q[i], "host rx word");
      tick(4);
      waitb(1, 1'b1);
    end
    host.rd(`HPD_HA_ISR, r8);
    chk(r8[0] === 1'b0 && host_rx_req_n === 1'b1, "rx bytes empty");
    $display("test core_to_host done");
    exp_q = {};
    {rx_full_irq_enable, tx_empty_irq_enable} = seed[9:8];
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      exp_q.push_back(seed[23:0]);
      hw(seed[23:0]);
      tick(4);
      host.rd(`HPD_HA_ISR, r8);
      chk(r8[1] === (i < 5), "tx bytes empty");
    end
    dma_chk(1'b1);
    for (int i = 0; i < 6; i++) begin
      waitb(0, 1'b1);
      chk(core_rx_word_reg === exp_q[i], "rx word");
      pulse(0);
      tick(2);
    end
    tick(3);
    chk(core_stat_reg[0] === 1'b0, "rx word empty");
    host.rd(`HPD_HA_ISR, r8);
    chk(r8[1] === 1'b1, "tx bytes drained");
    dma_chk(1'b0);
    $display("test fill_drain done");
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : seed[6:0];
      command_irq_enable = (i != 2);
      host.wr(`HPD_HA_CVR, {1'b1, v});
      tick(2);
      chk(cmd_irq_req === (i != 2), "command mask");
      command_irq_enable = 1'b1;
      tick(2);
      chk(cmd_irq_req === 1'b1 && cmd_vector_addr === vaddr(v), "command vector");
      pulse(2);
      chk(cmd_irq_req === 1'b0, "command ack");
      host.rd(`HPD_HA_CVR, r8);
      chk(r8[7] === 1'b0, "pending bit");
    end
    $display("test command done");
    core_stop = 1'b1;
    tick(2);
    host.wr(`HPD_HA_ICR, 8'h18);
    host.rd(`HPD_HA_ISR, r8);
    chk(core_stat_reg[4:3] === 2'b00, "stop write");
    chk(host.oe_seen === 1'b1, "stop drive");
    core_stop = 1'b0;
    tick(4);
    $display("test stop done");
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up;
  end
endmodule
